// ==== rtl/lvs_delay_timer.sv ====
// Seconds-resolution delay timer for switch-on and switch-off delays.
// Assumes one core clock, asynchronous active-low reset, a one-second tick.
module lvs_delay_timer
	import lvs_pkg::*;
(
	input wire logic core_clk_i, // Core clock
	input wire logic rstn_i, // Asynchronous reset, active low
	lvs_timer_if.tmr tif // Control from the scheduler
);
	tmr_state_t state_q; // Running or idle
	logic [11:0] cnt_q; // Seconds left
	logic expire_q; // Expiry pulse

	// Last second of the delay
	wire last_w = tif.tick && (cnt_q == 12'h001);

	assign tif.busy = (state_q == TMR_RUN);
	assign tif.expire = expire_q;

	// Countdown; a start is taken only when idle, so a restart never stretches a delay
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_q <= TMR_IDLE;
			cnt_q <= 12'h000;
			expire_q <= 1'b0;
		end
		else
		begin
			expire_q <= 1'b0;
			case (state_q)
				TMR_IDLE:
				begin
					if (tif.start)
					begin
						cnt_q <= tif.secs;
						state_q <= TMR_RUN;
					end
				end
				TMR_RUN:
				begin
					// Abandoned delay leaves no expiry behind
					if (tif.cancel)
						state_q <= TMR_IDLE;
					else if (last_w)
					begin
						expire_q <= 1'b1;
						state_q <= TMR_IDLE;
					end
					else if (tif.tick)
						cnt_q <= cnt_q - 12'h001;
				end
				default: state_q <= TMR_IDLE;
			endcase
		end
	end
endmodule // lvs_delay_timer

// ==== rtl/lvs_map.svh ====
// Constants of the limit value output scheduler: timing, threshold steps,
// hysteresis steps and delay choices. Included by the design files only.
`ifndef LVS_MAP_SVH
`define LVS_MAP_SVH

// Core clock period and the length of one second, in nanoseconds
`define LVS_CLK_NS 50
`define LVS_SEC_NS 1000000000
// Clock cycles per second (a longest-time count, rounded down)
`define LVS_TICK_CYCLES (`LVS_SEC_NS / `LVS_CLK_NS)
// Cyclic repeat base in seconds and the largest cyclic setting
`define LVS_CYC_BASE_S 11'h00A
`define LVS_CYC_MAX 7'h78

// Configured threshold steps, in 0.1 degC
`define LVS_THR_IDX_LINEAR_LO 6'h02
`define LVS_THR_IDX_LINEAR_HI 6'h2A
`define LVS_THR_IDX_OFFSET 6'h07
`define LVS_THR_STEP 16'sh000A
`define LVS_THR_M15 16'shFF6A
`define LVS_THR_M10 16'shFF9C
`define LVS_THR_P40 16'sh0190
`define LVS_THR_P45 16'sh01C2
`define LVS_THR_P50 16'sh01F4

// Percent object scaling: 0 -> -20 degC, full scale -> 55 degC (0.1 degC units)
`define LVS_PCT_BASE 17'sh1FF38
`define LVS_PCT_SPAN 10'h2EE
`define LVS_PCT_FULL 18'h000FF

// Hysteresis steps, in 0.1 K
`define LVS_HYS_1K 16'sh000A
`define LVS_HYS_2K 16'sh0014
`define LVS_HYS_3K 16'sh001E
`define LVS_HYS_4K 16'sh0028
`define LVS_HYS_5K 16'sh0032
`define LVS_HYS_10K 16'sh0064
`define LVS_HYS_15K 16'sh0096
`define LVS_HYS_20K 16'sh00C8

// Switch-on and switch-off delay choices, in seconds
`define LVS_DLY_1S 12'h001
`define LVS_DLY_3S 12'h003
`define LVS_DLY_5S 12'h005
`define LVS_DLY_10S 12'h00A
`define LVS_DLY_15S 12'h00F
`define LVS_DLY_30S 12'h01E
`define LVS_DLY_1M 12'h03C
`define LVS_DLY_3M 12'h0B4
`define LVS_DLY_5M 12'h12C
`define LVS_DLY_10M 12'h258
`define LVS_DLY_15M 12'h384
`define LVS_DLY_30M 12'h708
`define LVS_DLY_60M 12'hE10

`endif

// ==== rtl/lvs_pkg.sv ====
// Types shared by the limit value output scheduler.
// Assumes the constants of lvs_map.svh for all numeric values.
package lvs_pkg;
	// Source of the limiting value
	typedef enum logic [1:0] {EXT_NONE, EXT_WORD, EXT_BYTE, EXT_TEACH} ext_src_t;
	// Delay timer states
	typedef enum logic {TMR_IDLE, TMR_RUN} tmr_state_t;
endpackage

// ==== rtl/lvs_scheduler.sv ====
// Limit value output scheduler: threshold source, crossing detection,
// switch delays and transmit scheduling of one 1-bit limit object.
// Assumes synchronous inputs, a 20 MHz core clock and a transmit path that
// takes every one-cycle request.
// Operation
// - 16-bit source takes threshold from word object
// - 8-bit source uses byte; none uses configured
// - Teaching captures present measurement as threshold
// - Teach capture only on 0-to-1 edge
// - Download discards external value until new received
// - Switch-on delay before accepting state 1
// - Cyclic sends carry 0 during on-delay
// - Switch-off delay before accepting state 0
// - Cyclic sends carry 1 during off-delay
// - No-telegram condition also suppresses cyclic sends
// - Send on each accepted change when enabled
// - No change sends when send-on-change disabled
// - Cyclic period is setting times ten seconds
// - Cyclic setting zero disables periodic sending
// - Nonzero setting sends cyclically regardless of changes
// - Configured threshold steps from -15 to 50 degC
// - Set or clear on directed threshold crossing
// - Hysteresis steps none up to 20 K
// - Twelve activation action combinations
`include "lvs_map.svh"
module lvs_scheduler
	import lvs_pkg::*;
#(
	parameter int TICK_CYCLES = `LVS_TICK_CYCLES // Core cycles per second
)
(
	input wire logic core_clk_i, // Core clock, 20 MHz
	input wire logic rstn_i, // Asynchronous reset, active low
	input wire logic signed [15:0] meas_i, // Measured value, 0.1 degC
	input wire logic [5:0] thr_sel_i, // Configured threshold step 0..45
	input wire logic [3:0] hyst_sel_i, // Hysteresis step 0..8
	input wire logic [3:0] act_sel_i, // Activation action 0..11
	input wire logic [1:0] ext_mode_i, // Threshold source
	input wire logic ext_word_wr_i, // Word object received
	input wire logic signed [15:0] ext_word_i, // Word threshold, 0.1 degC
	input wire logic ext_byte_wr_i, // Byte object received
	input wire logic [7:0] ext_byte_i, // Byte threshold, percent of range
	input wire logic teach_i, // Teaching switch object level
	input wire logic download_i, // Configuration download pulse
	input wire logic [3:0] on_dly_sel_i, // Switch-on delay choice 0..13
	input wire logic [3:0] off_dly_sel_i, // Switch-off delay choice 0..13
	input wire logic soc_en_i, // Send on change enable
	input wire logic [6:0] cyc_sel_i, // Cyclic setting 0..120
	output logic tx_req_o, // Transmit request pulse
	output logic tx_val_o, // Value to transmit
	output logic limit_state_o, // Accepted limit state
	output logic signed [15:0] threshold_level_o, // Active threshold
	output logic delay_busy_o // A switch delay is running
);
	lvs_timer_if tif (); // Link to the delay timer

	logic [24:0] tick_cnt_q; // Clock cycles within the second
	logic sec_tick_q; // One-second pulse
	logic [10:0] cyc_sec_q; // Seconds since last cyclic repeat point, sent or muted
	logic signed [15:0] ext_q; // Externally supplied threshold
	logic ext_valid_q; // External threshold usable
	logic teach_prev_q; // Previous teach level
	logic region_q; // 1 after set crossing, 0 after release crossing
	logic acc_q; // Accepted limit state
	logic tx_req_q; // Registered transmit request
	logic tx_val_q; // Registered transmit value

	ext_src_t src_w; // Decoded threshold source
	assign src_w = ext_src_t'(ext_mode_i);

	// Configured threshold step to 0.1 degC
	function automatic logic signed [15:0] cfg_thr(input logic [5:0] idx);
		logic signed [15:0] rel;
		// Offset taken at full width; a 6-bit difference would turn 32..35 degC negative
		rel = signed'({10'h000, idx}) - signed'(16'(`LVS_THR_IDX_OFFSET));
		if (idx == 6'h00)
			cfg_thr = `LVS_THR_M15;
		else if (idx < `LVS_THR_IDX_LINEAR_LO)
			cfg_thr = `LVS_THR_M10;
		else if (idx <= `LVS_THR_IDX_LINEAR_HI)
			cfg_thr = 16'(rel * `LVS_THR_STEP);
		else if (idx == `LVS_THR_IDX_LINEAR_HI + 6'h01)
			cfg_thr = `LVS_THR_P40;
		else if (idx == `LVS_THR_IDX_LINEAR_HI + 6'h02)
			cfg_thr = `LVS_THR_P45;
		else
			cfg_thr = `LVS_THR_P50;
	endfunction

	// hysteresis step table
	// Hysteresis step to 0.1 K
	function automatic logic signed [15:0] hyst_val(input logic [3:0] sel);
		case (sel)
			4'h1: hyst_val = `LVS_HYS_1K;
			4'h2: hyst_val = `LVS_HYS_2K;
			4'h3: hyst_val = `LVS_HYS_3K;
			4'h4: hyst_val = `LVS_HYS_4K;
			4'h5: hyst_val = `LVS_HYS_5K;
			4'h6: hyst_val = `LVS_HYS_10K;
			4'h7: hyst_val = `LVS_HYS_15K;
			4'h8: hyst_val = `LVS_HYS_20K;
			default: hyst_val = 16'sh0000;
		endcase
	endfunction

	// Delay choice to seconds; zero means no delay
	function automatic logic [11:0] dly_secs(input logic [3:0] sel);
		case (sel)
			4'h1: dly_secs = `LVS_DLY_1S;
			4'h2: dly_secs = `LVS_DLY_3S;
			4'h3: dly_secs = `LVS_DLY_5S;
			4'h4: dly_secs = `LVS_DLY_10S;
			4'h5: dly_secs = `LVS_DLY_15S;
			4'h6: dly_secs = `LVS_DLY_30S;
			4'h7: dly_secs = `LVS_DLY_1M;
			4'h8: dly_secs = `LVS_DLY_3M;
			4'h9: dly_secs = `LVS_DLY_5M;
			4'hA: dly_secs = `LVS_DLY_10M;
			4'hB: dly_secs = `LVS_DLY_15M;
			4'hC: dly_secs = `LVS_DLY_30M;
			4'hD: dly_secs = `LVS_DLY_60M;
			default: dly_secs = 12'h000;
		endcase
	endfunction

	wire logic signed [15:0] cfg_thr_w = cfg_thr(thr_sel_i);
	// Percent object scaled onto -20..55 degC; the divide is by a constant
	wire logic [17:0] pct_prod_w = 18'(ext_byte_i * `LVS_PCT_SPAN);
	wire logic [17:0] pct_scaled_w = pct_prod_w / `LVS_PCT_FULL;
	wire logic signed [15:0] pct_thr_w = 16'(`LVS_PCT_BASE + signed'({1'b0, pct_scaled_w[15:0]}));
	// rising edge of the switching object only
	wire logic teach_rise_w = teach_i && !teach_prev_q;
	wire logic teach_cap_w = (src_w == EXT_TEACH) && teach_rise_w;
	wire logic word_cap_w = (src_w == EXT_WORD) && ext_word_wr_i;
	wire logic byte_cap_w = (src_w == EXT_BYTE) && ext_byte_wr_i;
	wire logic ext_cap_w = teach_cap_w || word_cap_w || byte_cap_w;
	// no source or no fresh value falls back to configuration
	wire logic use_ext_w = (src_w != EXT_NONE) && ext_valid_q;
	wire logic signed [15:0] thr_w = use_ext_w ? ext_q : cfg_thr_w;

	// Crossing points, one bit wider so the hysteresis offset cannot wrap
	wire logic signed [16:0] thr17_w = 17'(thr_w);
	wire logic signed [16:0] hys17_w = 17'(hyst_val(hyst_sel_i));
	wire logic signed [16:0] meas17_w = 17'(meas_i);
	// Action code: bit1 undershoot variant, bit0 inverted values, bits 3:2 silent side
	wire logic under_w = act_sel_i[1];
	wire logic inv_w = act_sel_i[0];
	wire logic set_silent_w = (act_sel_i[3:2] == 2'b10);
	wire logic clr_silent_w = (act_sel_i[3:2] == 2'b01);
	// set crossing at the threshold, release at threshold -/+ hysteresis
	wire logic set_hit_w = under_w ? (meas17_w < thr17_w) : (meas17_w > thr17_w);
	wire logic clr_hit_w = under_w ? (meas17_w > thr17_w + hys17_w) : (meas17_w < thr17_w - hys17_w);
	// the fulfilled condition decides value or silence
	wire logic silent_w = region_q ? set_silent_w : clr_silent_w;
	wire logic raw_w = silent_w ? acc_q : (region_q ? !inv_w : inv_w);

	// Delay toward the pending state
	wire logic [11:0] on_secs_w = dly_secs(on_dly_sel_i);
	wire logic [11:0] off_secs_w = dly_secs(off_dly_sel_i);
	wire logic [11:0] dir_secs_w = raw_w ? on_secs_w : off_secs_w;
	wire logic pend_w = (raw_w != acc_q);
	// accept only at expiry, or at once with no delay set
	wire logic accept_w = pend_w && (tif.expire || (dir_secs_w == 12'h000 && !tif.busy));

	// Cyclic schedule: period is setting times base
	wire logic [10:0] period_w = 11'(cyc_sel_i * `LVS_CYC_BASE_S);
	wire logic cyc_hit_w = sec_tick_q && (cyc_sel_i != 7'h00) && (cyc_sec_q + 11'h001 >= period_w);
	// silent condition also mutes the cyclic telegram
	wire logic cyc_send_w = cyc_hit_w && !silent_w;
	wire logic chg_send_w = accept_w && soc_en_i;

	assign tif.start = pend_w && !tif.busy && !tif.expire && (dir_secs_w != 12'h000);
	// raw state back at accepted state abandons the delay
	assign tif.cancel = tif.busy && !pend_w;
	assign tif.secs = dir_secs_w;
	assign tif.tick = sec_tick_q;

	assign tx_req_o = tx_req_q;
	assign tx_val_o = tx_val_q;
	assign limit_state_o = acc_q;
	assign threshold_level_o = thr_w;
	assign delay_busy_o = tif.busy;

	// Switch delay timer
	lvs_delay_timer u_timer (
		.core_clk_i (core_clk_i),
		.rstn_i (rstn_i),
		.tif (tif.tmr)
	);

	// One-second timebase
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tick_cnt_q <= 25'h0000000;
			sec_tick_q <= 1'b0;
		end
		else
		begin
			sec_tick_q <= (tick_cnt_q == 25'(TICK_CYCLES - 1));
			tick_cnt_q <= (tick_cnt_q == 25'(TICK_CYCLES - 1)) ? 25'h0000000 : tick_cnt_q + 25'h0000001;
		end
	end

	// seconds counter for the cyclic repeat
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			cyc_sec_q <= 11'h000;
		else if (cyc_sel_i == 7'h00 || cyc_hit_w)
			cyc_sec_q <= 11'h000;
		else if (sec_tick_q)
			cyc_sec_q <= cyc_sec_q + 11'h001;
	end

	// External threshold store; a fresh value wins over a download clear
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ext_q <= 16'sh0000;
			ext_valid_q <= 1'b0;
			teach_prev_q <= 1'b0;
		end
		else
		begin
			teach_prev_q <= teach_i;
			if (word_cap_w)
				ext_q <= ext_word_i;
			else if (byte_cap_w)
				ext_q <= pct_thr_w;
			else if (teach_cap_w)
				ext_q <= meas_i;
			if (ext_cap_w)
				ext_valid_q <= 1'b1;
			else if (download_i)
				ext_valid_q <= 1'b0;
		end
	end

	// Crossing region, accepted state and transmit requests
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			region_q <= 1'b0;
			acc_q <= 1'b0;
			tx_req_q <= 1'b0;
			tx_val_q <= 1'b0;
		end
		else
		begin
			if (set_hit_w)
				region_q <= 1'b1;
			else if (clr_hit_w)
				region_q <= 1'b0;
			if (accept_w)
				acc_q <= raw_w;
			tx_req_q <= chg_send_w || cyc_send_w;
			// cyclic value is the accepted state, not the raw one
			tx_val_q <= accept_w ? raw_w : acc_q;
		end
	end

	// Teach capture takes the measurement present at the edge
	teach_cap_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		teach_cap_w |=> (ext_q == $past(meas_i)) && ext_valid_q)
		else $error("teach did not capture measurement");

	// Download without a new value leaves the configured threshold in force
	download_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		download_i && !ext_cap_w ##1 (!ext_cap_w)[*2] |-> threshold_level_o == cfg_thr_w)
		else $error("external threshold survived download");

	// Word source drives the active threshold
	word_src_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		word_cap_w ##1 src_w == EXT_WORD |-> threshold_level_o == $past(ext_word_i))
		else $error("word object not used as threshold");

	// No source means configured threshold
	no_src_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		src_w == EXT_NONE |-> threshold_level_o == cfg_thr_w)
		else $error("threshold not configured value");

	// A delayed rise only happens at timer expiry
	on_delay_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(acc_q) && $past(on_secs_w) != 12'h000 |-> $past(tif.expire))
		else $error("state 1 accepted before delay");

	// A delayed fall only happens at timer expiry
	off_delay_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(acc_q) && $past(off_secs_w) != 12'h000 |-> $past(tif.expire))
		else $error("state 0 accepted before delay");

	// Every telegram carries the accepted state
	tx_value_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		tx_req_o |-> tx_val_o == acc_q)
		else $error("telegram value differs from accepted state");

	// Without change sending or cycle no telegram appears
	no_send_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!soc_en_i && cyc_sel_i == 7'h00 |=> !tx_req_o)
		else $error("telegram with sending disabled");

	// Silent condition mutes the cyclic telegram
	cyc_silent_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		cyc_hit_w && silent_w && !accept_w |=> !tx_req_o)
		else $error("cyclic telegram not suppressed");

	// Return of the raw state ends the delay next cycle
	delay_cancel_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		tif.busy && !pend_w |=> !tif.busy && $stable(acc_q))
		else $error("delay not cancelled");
endmodule // lvs_scheduler

// ==== rtl/lvs_timer_if.sv ====
// Carrier between the scheduler and its delay timer.
// Assumes both ends run on the same core clock.
interface lvs_timer_if;
	logic start; // Load and run the timer
	logic cancel; // Abandon a running delay
	logic [11:0] secs; // Delay length in seconds, nonzero on start
	logic tick; // One-second timebase pulse
	logic busy; // Timer running
	logic expire; // One-cycle pulse at delay end
	modport ctl (output start, output cancel, output secs, output tick, input busy, input expire);
	modport tmr (input start, input cancel, input secs, input tick, output busy, output expire);
endinterface

// ==== sim/lvs_tx_sink.sv ====
// Transmit path model that takes limit telegrams from the scheduler.
// Assumes one-cycle requests on the core clock; every request is taken.
module lvs_tx_sink
(
	input wire logic core_clk_i, // Core clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic tx_req_i, // Request pulse
	input wire logic tx_val_i, // Value carried
	output logic [15:0] tx_cnt_o, // Telegrams taken
	output logic last_val_o, // Latest value
	output logic [15:0] gap_o // Cycles between last two
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] age_q; // Cycles since latest telegram
	// Take each request at once; the bus never stalls in this model
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tx_cnt_o <= 16'h0000;
			last_val_o <= 1'b0;
			gap_o <= 16'h0000;
			age_q <= 16'h0000;
		end
		else if (tx_req_i)
		begin
			tx_cnt_o <= tx_cnt_o + 16'h0001;
			last_val_o <= tx_val_i;
			gap_o <= age_q + 16'h0001;
			age_q <= 16'h0000;
		end
		else
		begin
			age_q <= age_q + 16'h0001;
		end
	end
endmodule // lvs_tx_sink

// ==== sim/tb.sv ====
// Self-checking bench of the limit value output scheduler.
// Assumes one second shortened to 4 core cycles.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rstn, wwr, bwr, teach, dl, soc;
	logic signed [15:0] meas, word;
	logic [5:0] thr_sel;
	logic [3:0] hyst, act, on_d, off_d;
	logic [1:0] mode;
	logic [7:0] byt;
	logic [6:0] cyc;
	logic tx_req, tx_val, limit, busy, lval;
	logic signed [15:0] thr;
	logic [15:0] cnt, gap, c;
	int n_fail = 0;
	int checks_done = 0;
	// Step table of the configured threshold
	logic [5:0] sel_t[7] = '{6'h00, 6'h01, 6'h02, 6'h2A, 6'h2B, 6'h2C, 6'h2D};
	logic [15:0] thr_t[7] = '{16'hFF6A, 16'hFF9C, 16'hFFCE, 16'h015E, 16'h0190, 16'h01C2, 16'h01F4};
	// Action table: state on set and on release, 2 means hold
	logic [1:0] set_t[12] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2};
	logic [1:0] rel_t[12] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1};
	logic e;

	lvs_scheduler #(.TICK_CYCLES(4)) lvs_scheduler_i (.core_clk_i(clk), .rstn_i(rstn), .meas_i(meas),
		.thr_sel_i(thr_sel), .hyst_sel_i(hyst), .act_sel_i(act), .ext_mode_i(mode), .ext_word_wr_i(wwr),
		.ext_word_i(word), .ext_byte_wr_i(bwr), .ext_byte_i(byt), .teach_i(teach), .download_i(dl),
		.on_dly_sel_i(on_d), .off_dly_sel_i(off_d), .soc_en_i(soc), .cyc_sel_i(cyc), .tx_req_o(tx_req),
		.tx_val_o(tx_val), .limit_state_o(limit), .threshold_level_o(thr), .delay_busy_o(busy));
	lvs_tx_sink lvs_tx_sink_i (.core_clk_i(clk), .rstn_i(rstn), .tx_req_i(tx_req), .tx_val_i(tx_val),
		.tx_cnt_o(cnt), .last_val_o(lval), .gap_o(gap));

	// Free-running 50 ns clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Verdict and end of run
	task automatic test_done();
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Advance n edges, then step off the edge before driving
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic do_reset();
		rstn = 1'b0;
		tk(10);
		rstn = 1'b1;
		tk(1);
	endtask

	// Wait for the next telegram; a hang ends the run
	task automatic wait_tx(input int lim);
		logic [15:0] c0;
		c0 = cnt;
		for (int i = 0; i < lim && cnt === c0; i++)
			tk(1);
		if (cnt === c0)
		begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, cnt, c0 + 16'h0001);
			test_done();
		end
	endtask

	// One-cycle object write, then settle a cycle
	task automatic obj(input logic w, input logic [15:0] v);
		word = v;
		byt = v[7:0];
		wwr = w;
		bwr = !w;
		tk(1);
		wwr = 1'b0;
		bwr = 1'b0;
		tk(1);
	endtask

	initial
	begin
		rstn = 1'b0; meas = 16'sh0096; thr_sel = 6'h16; hyst = 4'h0; act = 4'h0; mode = 2'h0;
		wwr = 1'b0; word = 16'sh0000; bwr = 1'b0; byt = 8'h00; teach = 1'b0; dl = 1'b0;
		on_d = 4'h0; off_d = 4'h0; soc = 1'b1; cyc = 7'h00;
		do_reset();
		chk(limit, 16'h0000);
		chk(cnt, 16'h0000);
		for (int i = 0; i < 7; i++)
		begin
			thr_sel = sel_t[i];
			tk(1);
			chk(thr, thr_t[i]);
		end
		thr_sel = 6'h16;
		mode = 2'h1;
		obj(1'b1, 16'h00C8);
		chk(thr, 16'h00C8);
		dl = 1'b1;
		tk(1);
		dl = 1'b0;
		tk(1);
		chk(thr, 16'h0096);
		obj(1'b1, 16'h0064);
		chk(thr, 16'h0064);
		mode = 2'h2;
		obj(1'b0, 16'h00FF);
		chk(thr, 16'h0226);
		obj(1'b0, 16'h0000);
		obj(1'b1, 16'h0011);
		chk(thr, 16'hFF38);
		mode = 2'h0;
		tk(1);
		chk(thr, 16'h0096);
		// Source change comes with a download, which drops the stored byte value
		mode = 2'h3;
		dl = 1'b1;
		meas = 16'sh0123;
		tk(1);
		dl = 1'b0;
		tk(1);
		chk(thr, 16'h0096);
		teach = 1'b1;
		tk(2);
		chk(thr, 16'h0123);
		meas = 16'sh0200;
		tk(3);
		teach = 1'b0;
		tk(2);
		chk(thr, 16'h0123);
		mode = 2'h0;
		meas = 16'sh0096;
		do_reset();
		// Hysteresis of 1 K then of 20 K
		hyst = 4'h1;
		meas = 16'sh00A0;
		wait_tx(10);
		chk({limit, lval}, 16'h0003);
		meas = 16'sh008D;
		tk(10);
		chk(limit, 16'h0001);
		meas = 16'sh008B;
		wait_tx(10);
		chk({limit, lval}, 16'h0000);
		soc = 1'b0;
		hyst = 4'h8;
		c = cnt;
		meas = 16'sh00A0;
		tk(10);
		meas = 16'shFFCF;
		tk(10);
		chk(limit, 16'h0001);
		meas = 16'shFFCD;
		tk(10);
		chk(limit, 16'h0000);
		chk(cnt, c);
		// Switch-on delay of 3 s, abandoned and then served
		soc = 1'b1;
		hyst = 4'h0;
		on_d = 4'h2;
		meas = 16'sh00A0;
		tk(4);
		chk({busy, limit}, 16'h0002);
		meas = 16'sh0064;
		tk(3);
		chk(busy, 16'h0000);
		tk(20);
		chk(limit, 16'h0000);
		chk(cnt, c);
		meas = 16'sh00A0;
		tk(6);
		chk(limit, 16'h0000);
		wait_tx(20);
		chk({limit, lval}, 16'h0003);
		// Cyclic sends during long delays
		on_d = 4'h6;
		off_d = 4'h6;
		soc = 1'b0;
		cyc = 7'h01;
		meas = 16'sh0064;
		do_reset();
		meas = 16'sh00A0;
		wait_tx(50);
		wait_tx(50);
		chk({busy, lval}, 16'h0002);
		chk(gap, 16'h0028);
		tk(60);
		chk(limit, 16'h0001);
		wait_tx(50);
		chk(lval, 16'h0001);
		chk(gap, 16'h0028);
		meas = 16'sh0064;
		wait_tx(50);
		chk({busy, lval}, 16'h0003);
		wait_tx(50);
		chk({limit, lval}, 16'h0003);
		tk(80);
		chk(limit, 16'h0000);
		cyc = 7'h00;
		c = cnt;
		tk(100);
		chk(cnt, c);
		// Silent release side mutes cyclic sends
		on_d = 4'h0;
		off_d = 4'h0;
		soc = 1'b1;
		cyc = 7'h01;
		act = 4'h4;
		do_reset();
		meas = 16'sh00A0;
		wait_tx(10);
		meas = 16'sh0064;
		c = cnt;
		tk(100);
		chk(limit, 16'h0001);
		chk(cnt, c);
		// All twelve actions from a neutral start
		cyc = 7'h00;
		for (int a = 0; a < 12; a++)
		begin
			act = 4'(a);
			meas = 16'sh0096;
			do_reset();
			e = ((a / 2) % 2) == 0;
			meas = e ? 16'sh00A0 : 16'sh0064;
			tk(10);
			// A silent set side keeps what the released region gave after reset
			e = (set_t[a] == 2'h2) ? rel_t[a][0] : set_t[a][0];
			chk(limit, {15'h0000, e});
			meas = (((a / 2) % 2) == 0) ? 16'sh0064 : 16'sh00A0;
			tk(10);
			e = (rel_t[a] == 2'h2) ? e : rel_t[a][0];
			chk(limit, {15'h0000, e});
		end
		test_done();
	end
endmodule // tb
